// ---- design/ts_cfg.svh ----
// Constants of the trigger serialiser: widths, phases, slice layout.
// Assumes nothing; included by every design module file, not by the package.
`ifndef TS_CFG_SVH
`define TS_CFG_SVH
`define TS_WORD_W      10
`define TS_DATA_W      8
`define TS_FLAG_BIT    8
`define TS_PAR_BIT     9
`define TS_CHANS       4
`define TS_LINES       10
`define TS_FIELD_LINES 5
`define TS_FANOUT      4
`define TS_NIB_W       4
`define TS_SLICE_W     80
`define TS_CH_SLICE_W  20
`define TS_SP_T0       0
`define TS_SP_P0       8
`define TS_SP_T1       9
`define TS_SP_P1       17
`define TS_SP_FLAG     18
`define TS_SP_RDY      19
`define TS_PTR_W       7
`define TS_FIFO_DEPTH  128
`define TS_CNT_W       16
`define TS_PH_CAP      2'h0
`define TS_PH_SYNC     2'h1
`define TS_PH_LOAD     2'h2
`define TS_PH_BX       2'h3
`define TS_PH_STEP     2'h1
`define TS_SH_CNT_W    7
`define TS_SH_DONE     7'h50
`endif

// ---- design/ts_pkg.sv ----
// Types shared by the trigger serialiser modules.
// Assumes ts_cfg.svh for widths.
package ts_pkg;
    typedef enum logic [0:0]
    {
        TS_LIVE = 1'b0,
        TS_PLAY = 1'b1
    } ts_mode_type;
    typedef logic [1:0] ts_phase_type;
endpackage

// ---- design/ts_chan.sv ----
// One input channel: capture, sync stage, optional delay, demux, parity.
// Assumes the phase count of the top; inputs synchronous to clk.
`timescale 1ns/1ps
`include "ts_cfg.svh"
module ts_chan
    import ts_pkg::*;
#(
    parameter int CNT_W = `TS_CNT_W
)
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire ts_phase_type              ph,
    input  wire logic [`TS_WORD_W-1:0]     din,
    input  wire logic                      link_ready,
    input  wire logic                      delay_en,
    input  wire logic                      demux_bypass,
    input  wire logic                      count_en,
    output logic [`TS_WORD_W-1:0]          aligned_word,
    output logic [`TS_CH_SLICE_W-1:0]      slice_part,
    output logic                           ready_now,
    output logic                           parity_bad,
    output logic [CNT_W-1:0]               perr_count
);
    logic [`TS_WORD_W-1:0] cap_q;
    logic [`TS_WORD_W-1:0] sync_q;
    logic [`TS_WORD_W-1:0] dly_q;
    logic                  rdy_cap_q;
    logic                  rdy_q;
    logic [CNT_W-1:0]      cnt_q;
    wire logic             flag = aligned_word[`TS_FLAG_BIT];
    wire logic [`TS_DATA_W-1:0] data = aligned_word[`TS_DATA_W-1:0];
    wire logic             to_t1 = flag & ~demux_bypass;
    wire logic             cnt_max = &cnt_q;

    // ========================================
    // Capture and synchronise
    // word capture, sync
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cap_q     <= '0;
            sync_q    <= '0;
            dly_q     <= '0;
            rdy_cap_q <= 1'b0;
            rdy_q     <= 1'b0;
        end
        else if (ce && ph == `TS_PH_CAP)
        begin
            cap_q     <= din;
            rdy_cap_q <= link_ready;
        end
        else if (ce && ph == `TS_PH_SYNC)
        begin
            sync_q <= cap_q;
            dly_q  <= sync_q;
            rdy_q  <= rdy_cap_q;
        end
    end

    assign aligned_word = delay_en ? dly_q : sync_q;
    assign ready_now    = rdy_q;

    // ========================================
    // Demultiplex and parity
    // even parity check
    assign parity_bad = ^aligned_word;
    // demux bypass; both towers flagged on error
    assign slice_part = {rdy_q, flag, parity_bad,
                         to_t1 ? data : 8'h00, parity_bad,
                         to_t1 ? 8'h00 : data};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else if (ce && count_en && ph == `TS_PH_LOAD && parity_bad
                 && !cnt_max)
            cnt_q <= cnt_q + 1'b1;
    end
    assign perr_count = cnt_q;
endmodule

// ---- design/ts_fifo.sv ----
// Readout FIFO in flip-flops; head word visible without a pop.
// Assumes push and pop already gated by the clock enable.
`timescale 1ns/1ps
`include "ts_cfg.svh"
module ts_fifo
#(
    parameter int WIDTH = `TS_SLICE_W,
    parameter int DEPTH = `TS_FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic             pop,
    output logic [WIDTH-1:0]      head,
    output logic                  empty_q,
    output logic                  full
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    // Push while full is dropped; controller keeps to at most eight per accept
    wire logic        push_ok = push & ~full;
    wire logic        pop_ok  = pop & ~empty_q;
    wire logic [AW:0] cnt_d   = cnt_q + {{AW{1'b0}}, push_ok}
                                      - {{AW{1'b0}}, pop_ok};

    assign full = (cnt_q == (AW+1)'(DEPTH));
    assign head = mem_q[rd_q];

    always_ff @(posedge clk)
    begin
        if (push_ok)
            mem_q[wr_q] <= din;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            empty_q <= 1'b1;
        end
        else
        begin
            wr_q    <= push_ok ? AW'(wr_q + 1'b1) : wr_q;
            rd_q    <= pop_ok ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q   <= cnt_d;
            empty_q <= (cnt_d == '0);
        end
    end
endmodule

// ---- design/ts_serialiser.sv ----
// Trigger serialiser top: real-time nibble serialiser with fan-out,
// history RAM, readout FIFO and readout shift register.
// Assumes clk is the fast bit clock; one crossing spans four phases.
`timescale 1ns/1ps
`include "ts_cfg.svh"
// Contract
// - Take four 10-bit words each crossing
// - Two 20-bit fields onto five lines each
// - Towers on four lines, flags/errors fifth
// - Each nibble stream driven four times
// - Capture each channel, then sync stage
// - Optional one-crossing delay per channel
// - Fourth serial bit within 2.5 crossings
// - Count link losses, flag any loss
// - Bit clock phases derived from crossing
// - Write demuxed slice with status each crossing
// - Seven-bit pointers step and wrap
// - Read pointer leads write by programmed lag
// - Resync clears write, loads read pointer
// - Controller inputs sampled on clock edge
// - Readout enable copies slice to FIFO
// - FIFO 128 deep, empty flag low if data
// - Shift-load moves slice to shift register
// - Continuous shift, zeros after 80 bits
// - Demultiplexing can be bypassed
// - Parity check and error scalers
// - Test commands start, stop playback
module ts_serialiser
    import ts_pkg::*;
#(
    parameter int CNT_W = `TS_CNT_W,
    parameter int DEPTH = `TS_FIFO_DEPTH
)
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    input  wire logic [`TS_WORD_W-1:0]        link_word0,
    input  wire logic [`TS_WORD_W-1:0]        link_word1,
    input  wire logic [`TS_WORD_W-1:0]        link_word2,
    input  wire logic [`TS_WORD_W-1:0]        link_word3,
    input  wire logic [`TS_CHANS-1:0]         link_ready,
    input  wire logic [`TS_CHANS-1:0]         delay_enable,
    input  wire logic                         demux_bypass,
    input  wire logic [`TS_PTR_W-1:0]         readout_lag,
    input  wire logic                         counter_resync,
    input  wire logic                         readout_enable,
    input  wire logic                         shift_load_request,
    input  wire logic                         playback_start,
    input  wire logic                         playback_stop,
    output logic [`TS_LINES*`TS_FANOUT-1:0]   serial_line_q,
    output logic                              buffer_empty_flag_q,
    output logic                              readout_serial_q,
    output logic                              link_loss_q,
    output logic                              parity_error_q,
    output logic [CNT_W-1:0]                  link_loss_count_q
);
    ts_phase_type              ph_q;
    ts_mode_type               mode_q;
    ts_mode_type               mode_d;
    logic [`TS_PTR_W-1:0]      wr_q;
    logic [`TS_PTR_W-1:0]      rd_q;
    logic [`TS_SLICE_W-1:0]    mem_q [1 << `TS_PTR_W];
    logic [`TS_SLICE_W-1:0]    sreg_q;
    logic [`TS_SH_CNT_W-1:0]   sh_cnt_q;
    logic [`TS_NIB_W-1:0]      nib_q [`TS_LINES];
    logic [`TS_CHANS-1:0]      rdy_prev_q;
    logic [`TS_WORD_W-1:0]     link_word [`TS_CHANS];
    logic [`TS_WORD_W-1:0]     aligned [`TS_CHANS];
    logic [`TS_WORD_W-1:0]     word_sel [`TS_CHANS];
    logic [`TS_CH_SLICE_W-1:0] part [`TS_CHANS];
    logic [CNT_W-1:0]          perr_cnt [`TS_CHANS];
    logic [`TS_CHANS-1:0]      rdy_now;
    logic [`TS_CHANS-1:0]      perr_bad;
    logic [`TS_CHANS-1:0]      perr_any;
    logic [`TS_SLICE_W-1:0]    slice;
    logic [`TS_SLICE_W-1:0]    fifo_head;
    logic [`TS_NIB_W-1:0]      nib_new [`TS_LINES];

    wire logic bx     = ce && ph_q == `TS_PH_BX;
    wire logic load   = ce && ph_q == `TS_PH_LOAD;
    wire logic live   = (mode_q == TS_LIVE);
    wire logic [`TS_SLICE_W-1:0] ram_rd = mem_q[rd_q];
    wire logic loss_evt = |(rdy_prev_q & ~rdy_now);
    wire logic loss_max = &link_loss_count_q;
    wire logic fifo_pop = bx && shift_load_request;
    wire logic sreg_load = fifo_pop && !buffer_empty_flag_q;

    assign link_word[0] = link_word0;
    assign link_word[1] = link_word1;
    assign link_word[2] = link_word2;
    assign link_word[3] = link_word3;

    // ========================================
    // Crossing phases
    // four bit phases per crossing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ph_q <= `TS_PH_CAP;
        else if (ce)
            ph_q <= ph_q + `TS_PH_STEP;
    end

    // ========================================
    // Playback mode
    // start and stop on crossing
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            TS_LIVE:
                if (bx && playback_start)
                    mode_d = TS_PLAY;
            TS_PLAY:
                if (bx && playback_stop)
                    mode_d = TS_LIVE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mode_q <= TS_LIVE;
        else
            mode_q <= mode_d;
    end

    // ========================================
    // Input channels
    genvar c;
    generate
        for (c = 0; c < `TS_CHANS; c++)
        begin : g_chan
            wire logic [`TS_CH_SLICE_W-1:0] pb =
                ram_rd[c*`TS_CH_SLICE_W +: `TS_CH_SLICE_W];
            ts_chan #(.CNT_W(CNT_W)) u_chan
            (
                .clk          (clk),
                .rst          (rst),
                .ce           (ce),
                .ph           (ph_q),
                .din          (link_word[c]),
                .link_ready   (link_ready[c]),
                .delay_en     (delay_enable[c]),
                .demux_bypass (demux_bypass),
                .count_en     (live),
                .aligned_word (aligned[c]),
                .slice_part   (part[c]),
                .ready_now    (rdy_now[c]),
                .parity_bad   (perr_bad[c]),
                .perr_count   (perr_cnt[c])
            );
            // Playback rebuilds a word from the stored towers
            assign word_sel[c] = live ? aligned[c] :
                {pb[`TS_SP_P0], pb[`TS_SP_FLAG],
                 pb[`TS_SP_T1 +: `TS_DATA_W] |
                 pb[`TS_SP_T0 +: `TS_DATA_W]};
            assign slice[c*`TS_CH_SLICE_W +: `TS_CH_SLICE_W] = part[c];
            assign perr_any[c] = |perr_cnt[c];
        end
    endgenerate

    // ========================================
    // Nibble serialiser
    genvar l;
    genvar j;
    generate
        for (l = 0; l < `TS_LINES; l++)
        begin : g_line
            localparam int F = l / `TS_FIELD_LINES;
            localparam int K = l % `TS_FIELD_LINES;
            wire logic [2*`TS_DATA_W-1:0] towers =
                {word_sel[2*F+1][`TS_DATA_W-1:0],
                 word_sel[2*F][`TS_DATA_W-1:0]};
            if (K < `TS_FIELD_LINES - 1)
            begin : g_tow
                assign nib_new[l] = towers[K*`TS_NIB_W +: `TS_NIB_W];
            end
            else
            begin : g_flag
                assign nib_new[l] =
                    {word_sel[2*F+1][`TS_PAR_BIT],
                     word_sel[2*F][`TS_PAR_BIT],
                     word_sel[2*F+1][`TS_FLAG_BIT],
                     word_sel[2*F][`TS_FLAG_BIT]};
            end
            // load two phases after capture, MSB first
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    nib_q[l] <= '0;
                else if (load)
                    nib_q[l] <= nib_new[l] << 1;
                else if (ce)
                    nib_q[l] <= nib_q[l] << 1;
            end
            for (j = 0; j < `TS_FANOUT; j++)
            begin : g_fan
                always_ff @(posedge clk or posedge rst)
                begin
                    if (rst)
                        serial_line_q[l*`TS_FANOUT+j] <= 1'b0;
                    else if (load)
                        serial_line_q[l*`TS_FANOUT+j] <=
                            nib_new[l][`TS_NIB_W-1];
                    else if (ce)
                        serial_line_q[l*`TS_FANOUT+j] <=
                            nib_q[l][`TS_NIB_W-1];
                end
            end
        end
    endgenerate

    // ========================================
    // History RAM and pointers
    // slice write, frozen in playback
    always_ff @(posedge clk)
    begin
        if (load && live)
            mem_q[wr_q] <= slice;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else if (bx && counter_resync)
        begin
            wr_q <= '0;
            rd_q <= readout_lag;
        end
        else if (bx)
        begin
            wr_q <= wr_q + 1'b1;
            rd_q <= rd_q + 1'b1;
        end
    end

    // ========================================
    // Readout FIFO and shift register
    // sampled at crossing edge
    ts_fifo #(.WIDTH(`TS_SLICE_W), .DEPTH(DEPTH)) u_fifo
    (
        .clk     (clk),
        .rst     (rst),
        .push    (bx && readout_enable),
        .din     (ram_rd),
        .pop     (fifo_pop),
        .head    (fifo_head),
        .empty_q (buffer_empty_flag_q),
        .full    ()
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sreg_q   <= '0;
            sh_cnt_q <= `TS_SH_DONE;
        end
        else if (sreg_load)
        begin
            sreg_q   <= fifo_head;
            sh_cnt_q <= '0;
        end
        else if (bx)
        begin
            sreg_q   <= sreg_q << 1;
            sh_cnt_q <= (sh_cnt_q == `TS_SH_DONE) ? sh_cnt_q
                                                  : sh_cnt_q + 1'b1;
        end
    end
    assign readout_serial_q = sreg_q[`TS_SLICE_W-1];

    // ========================================
    // Link loss and parity monitors
    // loss scaler and sticky flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdy_prev_q        <= '0;
            link_loss_count_q <= '0;
            link_loss_q       <= 1'b0;
            parity_error_q    <= 1'b0;
        end
        else if (ce)
        begin
            rdy_prev_q        <= rdy_now;
            link_loss_count_q <= (loss_evt && !loss_max)
                                 ? link_loss_count_q + 1'b1
                                 : link_loss_count_q;
            link_loss_q       <= link_loss_q | loss_evt;
            parity_error_q    <= |perr_any;
        end
    end

    // ========================================
    // Checks
    sequence s_capture;
        ce && ph_q == `TS_PH_CAP && !delay_enable[0] && live;
    endsequence
    sequence s_run5;
        (ce && !delay_enable[0])[*5];
    endsequence
    sequence s_load_flag;
        load ##1 ce;
    endsequence

    a_fanout_copies: assert property (@(posedge clk) disable iff (rst)
        serial_line_q[3:0] == {4{serial_line_q[0]}})
        else $error("fan-out copies differ");
    a_nibble_latency: assert property (@(posedge clk) disable iff (rst)
        s_capture ##1 s_run5 |=> serial_line_q[0] == $past(link_word0[0], 6))
        else $error("fourth bit late or wrong");
    a_flag_line: assert property (@(posedge clk) disable iff (rst)
        s_load_flag |-> serial_line_q[16] == $past(word_sel[1][9], 1))
        else $error("error bit not first on fifth line");
    a_wr_ptr_step: assert property (@(posedge clk) disable iff (rst)
        bx && !counter_resync |=> wr_q == `TS_PTR_W'($past(wr_q) + 1'b1))
        else $error("write pointer did not step");
    a_ptr_lag_kept: assert property (@(posedge clk) disable iff (rst)
        bx && !counter_resync |=> `TS_PTR_W'(rd_q - wr_q) ==
            `TS_PTR_W'($past(rd_q) - $past(wr_q)))
        else $error("pointer lag changed");
    a_resync_load: assert property (@(posedge clk) disable iff (rst)
        bx && counter_resync |=> wr_q == '0 && rd_q == $past(readout_lag))
        else $error("resync did not reload pointers");
    a_ram_write: assert property (@(posedge clk) disable iff (rst)
        load && live |=> mem_q[$past(wr_q)] == $past(slice))
        else $error("slice not written");
    a_fifo_fill: assert property (@(posedge clk) disable iff (rst)
        bx && readout_enable && !shift_load_request |=> !buffer_empty_flag_q)
        else $error("empty flag high after push");
    a_shift_load: assert property (@(posedge clk) disable iff (rst)
        sreg_load |=> readout_serial_q == $past(fifo_head[`TS_SLICE_W-1]))
        else $error("shift register not loaded");
    a_shift_zeros: assert property (@(posedge clk) disable iff (rst)
        sh_cnt_q == `TS_SH_DONE |-> sreg_q == '0 && !readout_serial_q)
        else $error("nonzero after 80 bits");
    a_loss_flag: assert property (@(posedge clk) disable iff (rst)
        ce && loss_evt |=> link_loss_q && link_loss_count_q != '0)
        else $error("link loss not flagged");
    a_parity_flag: assert property (@(posedge clk) disable iff (rst)
        load && live && perr_bad[0] ##1 ce |=> parity_error_q)
        else $error("parity error not flagged");
endmodule

// ---- bench/ts_ctrl_model.sv ----
// Readout controller model: enables, loads and collects slices.
// Assumes ce held high and the same reset as the serialiser.
`timescale 1ns/1ps
module ts_ctrl_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [2:0]  slices,
    input  wire logic        empty_flag,
    input  wire logic        serial_in,
    output logic             readout_enable,
    output logic             shift_load_request,
    output logic [79:0]      slice_q,
    output logic [7:0]       done_q
);
    // ========================================
    // Crossing sequencer
    logic [1:0] ph_q;
    logic [2:0] st_q;
    logic [2:0] left_q;
    logic [6:0] bit_q;
    // requests move only after crossing edges
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {ph_q, st_q, readout_enable, shift_load_request} <= '0;
            done_q <= 8'h00;
        end
        else
        begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h3)
            begin
                case (st_q)
                3'h0:
                begin
                    readout_enable <= start;
                    left_q         <= slices;
                    st_q           <= start ? 3'h1 : 3'h0;
                end
                3'h1:
                begin
                    // one crossing of enable per slice
                    readout_enable <= (left_q != 3'h1);
                    left_q <= (left_q == 3'h1) ? slices : left_q - 3'h1;
                    st_q   <= (left_q == 3'h1) ? 3'h2 : 3'h1;
                end
                3'h2:
                begin
                    shift_load_request <= !empty_flag;
                    bit_q              <= 7'h7f;
                    st_q               <= empty_flag ? 3'h2 : 3'h3;
                end
                default:
                begin
                    // next load only after 80 bits
                    shift_load_request <= 1'b0;
                    slice_q <= {slice_q[78:0], serial_in};
                    bit_q   <= bit_q + 7'h1;
                    done_q  <= done_q + 8'(bit_q == 7'h4f);
                    left_q  <= left_q - 3'(bit_q == 7'h4f);
                    if (bit_q == 7'h4f)
                        st_q <= (left_q == 3'h1) ? 3'h0 : 3'h2;
                end
                endcase
            end
        end
    end
endmodule

// ---- bench/test_trigger_serialiser_readout.sv ----
// Testbench of the trigger serialiser: nibble lines, readout, monitors.
// Assumes ts_ctrl_model as the controller and ce held high throughout.
`timescale 1ns/1ps
module test_trigger_serialiser_readout;
    logic        clk, rst, byp, start, empty, rser, loss, perr, ren, sld;
    logic [9:0]  w [4];
    logic [3:0]  rdy, dly;
    logic [2:0]  nsl;
    logic        res, pbs, pbe;
    logic [39:0] lines, pl;
    logic [15:0] lcnt;
    logic [79:0] slice;
    logic [7:0]  done;
    int          miscompares, checked, edge_n, ph, n, lo;
    // Four 9-bit payloads a row; lines expected from exp_lines
    logic [35:0] rows [6] = '{36'h123456789, 36'hfedcba987, 36'h5a5a5a5a5,
                              36'ha5a5a5a5a, 36'h0ff00ff00, 36'h000000101};

    ts_serialiser i_ts_serialiser
    (
        .clk(clk), .rst(rst), .ce(1'b1),
        .link_word0(w[0]), .link_word1(w[1]),
        .link_word2(w[2]), .link_word3(w[3]),
        .link_ready(rdy), .delay_enable(dly), .demux_bypass(byp),
        .readout_lag(7'h05), .counter_resync(res),
        .readout_enable(ren), .shift_load_request(sld),
        .playback_start(pbs), .playback_stop(pbe),
        .serial_line_q(lines), .buffer_empty_flag_q(empty),
        .readout_serial_q(rser), .link_loss_q(loss),
        .parity_error_q(perr), .link_loss_count_q(lcnt)
    );
    ts_ctrl_model i_ts_ctrl_model
    (
        .clk(clk), .rst(rst), .start(start), .slices(nsl),
        .empty_flag(empty), .serial_in(rser), .readout_enable(ren),
        .shift_load_request(sld), .slice_q(slice), .done_q(done)
    );

    // ========================================
    // Expectations and helpers
    function automatic logic [39:0] exp_lines(input int j);
        logic [39:0] r;
        logic [15:0] t;
        logic [3:0]  nb;
        for (int f = 0; f < 2; f++)
        begin
            t = {w[2*f+1][7:0], w[2*f][7:0]};
            for (int k = 0; k < 5; k++)
            begin
                nb = (k < 4) ? t[4*k +: 4] :
                     {w[2*f+1][9], w[2*f][9], w[2*f+1][8], w[2*f][8]};
                r[(5*f+k)*4 +: 4] = {4{nb[3-j]}};
            end
        end
        return r;
    endfunction
    function automatic logic [79:0] exp_slice();
        logic [79:0] r;
        logic [7:0]  t;
        logic        hi;
        for (int c = 0; c < 4; c++)
        begin
            t = w[c][7:0];
            hi = w[c][8] && !byp;
            r[20*c +: 20] = {rdy[c], w[c][8], ^w[c], hi ? t : 8'h00,
                             ^w[c], hi ? 8'h00 : t};
        end
        return r;
    endfunction
    task automatic tick();
        @(posedge clk);
        ph = edge_n % 4;
        edge_n++;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // New words land just before a capture edge, so lateness shows
    task automatic run_row(input logic [35:0] row, input int lat);
        do tick(); while (ph != 3);
        for (int c = 0; c < 4; c++)
            w[c] <= {^row[9*c +: 9], row[9*c +: 9]};
        repeat (3 + lat) tick();
        for (int j = 0; j < 4; j++)
        begin
            #1;
            chk(80'(lines), 80'(exp_lines(j)));
            tick();
        end
    endtask
    task automatic readout(input logic [7:0] target);
        start <= 1'b1;
        repeat (4) tick();
        start <= 1'b0;
        n = 0;
        lo = 0;
        while (done !== target && n < 1000)
        begin
            tick();
            #1;
            n++;
            lo += int'(empty === 1'b0);
        end
    endtask
    task automatic wrap_up();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ========================================
    // Clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        repeat (10000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        rst = 1'b1;
        w = '{default: 10'h000};
        rdy = 4'hf;
        dly = 4'h0;
        byp = 1'b0;
        res = 1'b1;
        pbs = 1'b0;
        pbe = 1'b0;
        start = 1'b0;
        nsl = 3'h2;
        miscompares = 0;
        checked = 0;
        edge_n = 0;
        repeat (20) tick();
        #1;
        chk(80'({lines, empty, rser, loss, perr, lcnt}), 80'h80000);
        tick();
        rst <= 1'b0;
        edge_n = 0;
        for (int r = 0; r < 6; r++) run_row(rows[r], 0);
        // Resync held through the rows; pointers run free from here
        res <= 1'b0;
        // History must wrap once before every slot holds the held words
        repeat (520) tick();
        readout(8'h02);
        chk(slice, exp_slice());
        chk(80'(lo > 0), 80'h1);
        chk(80'({empty, rser}), 80'h2);
        tick();
        byp <= 1'b1;
        repeat (520) tick();
        readout(8'h04);
        chk(slice, exp_slice());
        tick();
        pbs <= 1'b1;
        repeat (4) tick();
        pbs <= 1'b0;
        // Live words go to zero; lines must keep the stored words
        pl = exp_lines(3);
        w <= '{default: 10'h000};
        repeat (8) tick();
        do tick(); while (ph != 1);
        #1;
        chk(80'(lines), 80'(pl));
        tick();
        pbe <= 1'b1;
        repeat (4) tick();
        pbe <= 1'b0;
        w[0] <= w[0] ^ 10'h200;
        repeat (12) tick();
        #1;
        chk(80'(perr), 80'h1);
        for (int i = 1; i < 3; i++)
        begin
            tick();
            rdy <= 4'hf;
            repeat (12) tick();
            rdy <= 4'hd;
            repeat (12) tick();
            #1;
            chk(80'({loss, lcnt}), 80'({1'b1, 16'(i)}));
        end
        tick();
        dly <= 4'hf;
        run_row(rows[1], 4);
        tick();
        rst <= 1'b1;
        tick();
        #1;
        chk(80'({lines, empty, rser, loss, perr, lcnt}), 80'h80000);
        wrap_up();
    end
endmodule
